// [design/sbarb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sbarb_regs.svh"
// Notes on behaviour
// (R1) Keep bus while nobody else requests
// (R2) Common request from bus or tied low
// (R3) Same request handling serial or parallel
// (R4) Enable high: yield to lower requester
// (R5) Enable low: lower master needs priority
// (R6) Bus request, enable low: yield higher only
// (R7) Bus request, enable high: yield any requester
// (R8) Tied low, enable high: arbitrate every access
// (R9) Priority out feeds next lower master
// (R10) Priority out only in serial scheme
// (R11) Lock held over multi-transfer operation
// (R12) Lock driven only when enabled
// (R13) Terminate line local or module driven
// (R14) Per line drive or receive option
// (R15) Route module DMA request by slot
// (R16) Four drives, or two for some
// (R17) Request only when pending, release at end
module sbarb_top #(
  // Drives served; a board option, two for some drive families
  parameter int DRIVE_CNT = `SBARB_MAX_DRIVES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transfer handshake from local engine
  input wire logic xfer_done,
  // System bus arbitration pins, active low
  input wire logic bprn_n,
  input wire logic hi_req_n,
  input wire logic cbrq_n_i,
  output logic cbrq_n_o,
  output logic cbrq_n_oe,
  output logic breq_n,
  output logic bpro_n_o,
  output logic bpro_n_oe,
  output logic lock_n_o,
  output logic lock_n_oe,
  // Expansion slot lines
  input wire logic [1:0] ext_term_i,
  output logic [1:0] external_terminate_line,
  input wire logic option0_slot_a_line_i,
  input wire logic option0_slot_b_line_i,
  input wire logic option1_slot_a_line_i,
  input wire logic option1_slot_b_line_i,
  output logic [3:0] option_line_o,
  output logic [3:0] option_line_oe,
  input wire logic module_dma_request_a,
  input wire logic module_dma_request_b,
  output logic dma_req
);
  typedef struct packed {
    // Software-visible control and slot words
    logic [31:0] ctrl;
    logic [31:0] slot;
    // Write address and data held until both are in
    logic aw_got;
    logic [3:0] aw;
    logic w_got;
    logic [31:0] wd;
    logic [3:0] ws;
    // Write response, held until taken
    logic bvalid;
    logic [1:0] bresp;
    // Read answer, held until taken
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Ready flags kept as flops so the ports come straight from them
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    // Two-stage synchronisers for the arbitration pins
    logic [1:0] s_bprn, s_hi, s_cbrq;
    // Two-stage synchronisers for the slot inputs
    logic [1:0] s_ta, s_tb, s_o0a, s_o0b, s_o1a, s_o1b, s_da, s_db;
    // Registered pin drives; request kept active low like its pin
    logic cbrq_oe, bpro_oe, breq_n, lock_oe;
    // Slot side results
    logic [1:0] term;
    logic [3:0] op_o, op_oe;
    logic dma;
  } sbarb_top_t;
  sbarb_top_t q_reg, q_next;
  sbarb_cfg_if cfg ();
  logic core_breq, core_cbrq, core_bpro, core_lock;
  logic [3:0] op_in; // Synchronised option inputs
  logic wr_fire;     // Both halves of a write held

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Drive count is a board option, not logic here
  // Only the two documented counts can be served
  if (DRIVE_CNT != `SBARB_MAX_DRIVES && DRIVE_CNT != `SBARB_MIN_DRIVES) begin : g_bad_drive_cnt
    $error("drive count must be four or two"); // R16
  end

  // ----------------------------------------
  // Arbiter core
  // ----------------------------------------
  // Synchronised pins go in; higher request flipped to active high
  sbarb_core u_core (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .bprn_n_s(q_reg.s_bprn[1]),
    .cbrq_n_s(q_reg.s_cbrq[1]),
    .hi_req_s(~q_reg.s_hi[1]),
    .breq(core_breq),
    .cbrq_drv(core_cbrq),
    .bpro_drv(core_bpro),
    .lock_drv(core_lock)
  );
  // Control fields drive the core straight from the register
  assign cfg.cbrq_bus = q_reg.ctrl[`SBARB_CTRL_CBRQ_BUS]; // R2
  assign cfg.any_en = q_reg.ctrl[`SBARB_CTRL_ANY_EN];
  assign cfg.serial = q_reg.ctrl[`SBARB_CTRL_SERIAL];
  assign cfg.lock_en = q_reg.ctrl[`SBARB_CTRL_LOCK_EN];
  assign cfg.lock_req = q_reg.ctrl[`SBARB_CTRL_LOCK_REQ];
  assign cfg.xfer_req = q_reg.ctrl[`SBARB_CTRL_XFER_REQ];
  assign cfg.xfer_done = xfer_done;

  // ----------------------------------------
  // Next state: bus slave, synchronisers, pins
  // ----------------------------------------
  always_comb begin
    // Default holds every field; only the branches below move state
    q_next = q_reg;
    op_in = {q_reg.s_o1b[1], q_reg.s_o1a[1], q_reg.s_o0b[1], q_reg.s_o0a[1]};
    // Two-stage synchronisers; first stage feeds only the second
    // A pin change reaches logic two edges later
    q_next.s_bprn = {q_reg.s_bprn[0], bprn_n};
    q_next.s_hi = {q_reg.s_hi[0], hi_req_n};
    q_next.s_cbrq = {q_reg.s_cbrq[0], cbrq_n_i};
    q_next.s_ta = {q_reg.s_ta[0], ext_term_i[0]};
    q_next.s_tb = {q_reg.s_tb[0], ext_term_i[1]};
    q_next.s_o0a = {q_reg.s_o0a[0], option0_slot_a_line_i};
    q_next.s_o0b = {q_reg.s_o0b[0], option0_slot_b_line_i};
    q_next.s_o1a = {q_reg.s_o1a[0], option1_slot_a_line_i};
    q_next.s_o1b = {q_reg.s_o1b[0], option1_slot_b_line_i};
    q_next.s_da = {q_reg.s_da[0], module_dma_request_a};
    q_next.s_db = {q_reg.s_db[0], module_dma_request_b};
    // Capture address and data in either order
    if (s_axi_awvalid && !q_reg.aw_got) begin
      q_next.aw_got = 1'b1;
      q_next.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_reg.w_got) begin
      q_next.w_got = 1'b1;
      q_next.wd = s_axi_wdata;
      q_next.ws = s_axi_wstrb;
    end
    // Commit once both halves are in and the last response is gone
    wr_fire = q_reg.aw_got && q_reg.w_got && !q_reg.bvalid;
    if (wr_fire) begin
      q_next.aw_got = 1'b0;
      q_next.w_got = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = 2'b00;
      case (q_reg.aw)
        `SBARB_CTRL_ADDR: begin
          // Byte strobes honoured per lane
          for (int i = 0; i < 4; i++) begin
            if (q_reg.ws[i]) q_next.ctrl[i*8 +: 8] = q_reg.wd[i*8 +: 8];
          end
        end
        `SBARB_SLOT_ADDR: begin
          // Byte strobes honoured per lane
          for (int i = 0; i < 4; i++) begin
            if (q_reg.ws[i]) q_next.slot[i*8 +: 8] = q_reg.wd[i*8 +: 8];
          end
        end
        `SBARB_STAT_ADDR: begin
          // Read-only; write ignored
        end
        default: begin
          q_next.bresp = 2'b10;
        end
      endcase
    end
    // Response leaves once the master takes it
    if (q_reg.bvalid && s_axi_bready) q_next.bvalid = 1'b0;
    // Read path, one outstanding
    if (s_axi_arvalid && !q_reg.rvalid) begin
      q_next.rvalid = 1'b1;
      q_next.rresp = 2'b00;
      // Status: state, owner, pin drives, synchronised slot inputs
      case (s_axi_araddr)
        `SBARB_CTRL_ADDR: q_next.rdata = q_reg.ctrl;
        `SBARB_SLOT_ADDR: q_next.rdata = q_reg.slot;
        `SBARB_STAT_ADDR: q_next.rdata = {17'h0_0000, op_in, q_reg.s_tb[1], q_reg.s_ta[1],
                                          core_lock, core_bpro, core_cbrq, core_breq,
                                          cfg.owner, cfg.state};
        default: begin
          q_next.rdata = 32'h0000_0000;
          q_next.rresp = 2'b10;
        end
      endcase
    end else if (q_reg.rvalid && s_axi_rready) begin
      // Answer taken; a new read may follow next cycle
      q_next.rvalid = 1'b0;
    end
    // Arbitration pins registered
    // Request pin kept active low in its flop
    q_next.breq_n = ~core_breq; // R17
    q_next.cbrq_oe = core_cbrq; // R1
    q_next.bpro_oe = core_bpro & cfg.serial; // R10
    q_next.lock_oe = core_lock & cfg.lock_en; // R11 R12
    // Terminate: bit set means driven locally, clear means module drives
    // Local termination holds the line whatever the module does
    q_next.term[0] = q_reg.slot[`SBARB_SLOT_TERM_A] ? 1'b1 : q_reg.s_ta[1]; // R13
    q_next.term[1] = q_reg.slot[`SBARB_SLOT_TERM_B] ? 1'b1 : q_reg.s_tb[1]; // R13
    // Option lines: drive the level held in the slot word's drive bits when configured to drive
    // A line set to receive is left undriven; its input is still synchronised
    q_next.op_oe = q_reg.slot[`SBARB_SLOT_OPDRV_LO +: 4]; // R14
    q_next.op_o = q_reg.slot[`SBARB_SLOT_DRV_LO +: 4]; // R14
    // DMA request routing: 01 slot B, 10 slot A, else shared
    // Shared setting ORs both, so neither slot is starved
    case (q_reg.slot[`SBARB_SLOT_DMA_LO +: 2])
      2'b01: q_next.dma = q_reg.s_db[1]; // R15
      2'b10: q_next.dma = q_reg.s_da[1]; // R15
      default: q_next.dma = q_reg.s_da[1] | q_reg.s_db[1]; // R15
    endcase
    // Readies follow the hold flags, one flop each
    q_next.aw_rdy = ~q_next.aw_got;
    q_next.w_rdy = ~q_next.w_got;
    q_next.ar_rdy = ~q_next.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset; active-low pin stages start at their idle high
  // level, so no false grant or request follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.ctrl <= `SBARB_CTRL_RESET;
      q_reg.slot <= `SBARB_SLOT_RESET;
      q_reg.s_bprn <= 2'b11;
      q_reg.s_hi <= 2'b11;
      q_reg.s_cbrq <= 2'b11;
      // Readies up and bus request off out of reset
      q_reg.aw_rdy <= 1'b1;
      q_reg.w_rdy <= 1'b1;
      q_reg.ar_rdy <= 1'b1;
      q_reg.breq_n <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------
  // Outputs straight from flip-flops or fixed levels
  // ----------------------------------------
  // Register bus
  assign s_axi_awready = q_reg.aw_rdy;
  assign s_axi_wready = q_reg.w_rdy;
  assign s_axi_bvalid = q_reg.bvalid;
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_arready = q_reg.ar_rdy;
  assign s_axi_rvalid = q_reg.rvalid;
  assign s_axi_rdata = q_reg.rdata;
  assign s_axi_rresp = q_reg.rresp;
  // Arbitration pins: request driven from its flop; others fixed low, enables carry the drive
  assign breq_n = q_reg.breq_n;
  assign cbrq_n_o = 1'b0;
  assign cbrq_n_oe = q_reg.cbrq_oe;
  assign bpro_n_o = 1'b0;
  assign bpro_n_oe = q_reg.bpro_oe;
  assign lock_n_o = 1'b0;
  assign lock_n_oe = q_reg.lock_oe;
  // Slot lines
  assign external_terminate_line = q_reg.term;
  assign option_line_o = q_reg.op_o;
  assign option_line_oe = q_reg.op_oe;
  assign dma_req = q_reg.dma;
endmodule : sbarb_top
`default_nettype wire

// [design/sbarb_regs.svh]
`ifndef SBARB_REGS_SVH
`define SBARB_REGS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SBARB_CTRL_ADDR 4'h0
`define SBARB_STAT_ADDR 4'h4
`define SBARB_SLOT_ADDR 4'h8
// Control field positions
`define SBARB_CTRL_CBRQ_BUS 0
`define SBARB_CTRL_ANY_EN 1
`define SBARB_CTRL_SERIAL 2
`define SBARB_CTRL_LOCK_EN 3
`define SBARB_CTRL_LOCK_REQ 4
`define SBARB_CTRL_XFER_REQ 5
`define SBARB_CTRL_RESET 32'h0000_0001
// Slot field positions
`define SBARB_SLOT_TERM_A 0
`define SBARB_SLOT_TERM_B 1
`define SBARB_SLOT_OPDRV_LO 2
`define SBARB_SLOT_DMA_LO 6
`define SBARB_SLOT_DRV_LO 8
`define SBARB_SLOT_RESET 32'h0000_0000
// Most drives allowed
`define SBARB_MAX_DRIVES 4
`define SBARB_MIN_DRIVES 2
`endif

// [design/sbarb_pkg.sv]
package sbarb_pkg;
  // Arbiter states, one-hot
  typedef enum logic [3:0] {
    SBARB_IDLE = 4'b0001,
    SBARB_WAIT = 4'b0010,
    SBARB_OWN  = 4'b0100,
    SBARB_REL  = 4'b1000
  } sbarb_state_t;
endpackage : sbarb_pkg

// [design/sbarb_cfg_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Configuration carried from top to arbiter core
interface sbarb_cfg_if;
  logic cbrq_bus;
  logic any_en;
  logic serial;
  logic lock_en;
  logic lock_req;
  logic xfer_req;
  logic xfer_done;
  logic owner;
  logic [3:0] state;
  modport top (output cbrq_bus, any_en, serial, lock_en, lock_req, xfer_req, xfer_done,
               input owner, state);
  modport core (input cbrq_bus, any_en, serial, lock_en, lock_req, xfer_req, xfer_done,
                output owner, state);
endinterface : sbarb_cfg_if
`default_nettype wire

// [design/sbarb_core.sv]
`timescale 1ns/10ps
`default_nettype none
// Arbiter state machine; bus inputs arrive already synchronised
module sbarb_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and transfer control
  sbarb_cfg_if.core cfg,
  // Synchronised bus inputs; higher request active high, others active low
  input wire logic bprn_n_s,
  input wire logic cbrq_n_s,
  input wire logic hi_req_s,
  // Bus outputs, active levels
  output logic breq,
  output logic cbrq_drv,
  output logic bpro_drv,
  output logic lock_drv
);
  typedef struct packed {
    sbarb_pkg::sbarb_state_t st;
    logic breq;
    logic cbrq;
    logic bpro;
    logic lock;
  } sbarb_core_t;
  sbarb_core_t q_reg, q_next;
  logic cbrq_in; // Selected common request, active high
  logic yield;   // Another master needs the bus

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_next = q_reg;
    // Common request from bus or tied low (R2), same in both schemes (R3)
    // Tied low reads as a standing request, so ownership is never kept
    cbrq_in = cfg.cbrq_bus ? ~cbrq_n_s : 1'b1; // R2 R3
    // Any request when enabled (R4 R7); higher priority only otherwise (R5 R6)
    yield = cfg.any_en ? cbrq_in : (cbrq_in & hi_req_s); // R4 R5 R6 R7
    case (q_reg.st)
      sbarb_pkg::SBARB_IDLE: begin
        // Request only with a pending transfer
        if (cfg.xfer_req) begin
          q_next.st = sbarb_pkg::SBARB_WAIT; // R17
          q_next.breq = 1'b1;
          q_next.cbrq = 1'b1;
        end
      end
      sbarb_pkg::SBARB_WAIT: begin
        // Granted when priority input is low
        if (!bprn_n_s) begin
          q_next.st = sbarb_pkg::SBARB_OWN;
          q_next.cbrq = 1'b0;
          q_next.lock = cfg.lock_en & cfg.lock_req; // R11 R12
        end
      end
      sbarb_pkg::SBARB_OWN: begin
        q_next.lock = cfg.lock_en & cfg.lock_req; // R11 R12
        if (cfg.xfer_done) begin
          // Tied-low request: new arbitration per access (R8)
          if (!cfg.cbrq_bus || yield || !cfg.xfer_req) begin
            q_next.st = sbarb_pkg::SBARB_REL; // R1 R8 R17
            q_next.breq = 1'b0;
            q_next.lock = 1'b0;
          end
        end
      end
      sbarb_pkg::SBARB_REL: begin
        // One cycle with bus released
        q_next.st = sbarb_pkg::SBARB_IDLE;
      end
      default: begin
        q_next = '0;
        q_next.st = sbarb_pkg::SBARB_IDLE;
      end
    endcase
    // Priority out passes on only in serial scheme and when not using bus
    q_next.bpro = cfg.serial & (q_next.st == sbarb_pkg::SBARB_IDLE) & ~bprn_n_s; // R10 R9
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.st <= sbarb_pkg::SBARB_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  assign breq = q_reg.breq;
  assign cbrq_drv = q_reg.cbrq & cfg.cbrq_bus;
  assign bpro_drv = q_reg.bpro;
  assign lock_drv = q_reg.lock;
  assign cfg.owner = (q_reg.st == sbarb_pkg::SBARB_OWN);
  assign cfg.state = q_reg.st;
endmodule : sbarb_core
`default_nettype wire

// [verification/sbarb_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module sbarb_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Arbitration pins
  input wire logic breq_n,
  input wire logic cbrq_n_o,
  input wire logic cbrq_n_oe,
  input wire logic bpro_n_oe,
  input wire logic lock_n_oe
);
  // Shadow of control word, taken on the data beat
  logic [5:0] ctrl_sh_reg;
  // Cycles since a write; outputs may lag the register a few cycles
  logic [3:0] age_reg;
  wire logic fresh = age_reg < 4'h8;
  // Shadow and age update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_sh_reg <= 6'h01;
      age_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      if (s_axi_awaddr == 4'h0) ctrl_sh_reg <= s_axi_wdata[5:0];
      age_reg <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bpro_serial_only: assert property (bpro_n_oe |-> ctrl_sh_reg[2] || fresh)
    else $error("priority out driven in parallel scheme");
  a_lock_enable_only: assert property (lock_n_oe |-> ctrl_sh_reg[3] || fresh)
    else $error("lock driven while disabled");
  a_lock_while_req: assert property (lock_n_oe |-> !breq_n)
    else $error("lock driven without bus request");
  a_req_only_pending: assert property (!breq_n |-> ctrl_sh_reg[5] || fresh)
    else $error("bus request without pending transfer");
  a_cbrq_drive_low: assert property (cbrq_n_oe |-> cbrq_n_o == 1'b0 && !breq_n)
    else $error("common request driven high");
  a_bvalid_stays: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_stays: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule : sbarb_chk
bind sbarb_top sbarb_chk chk_u (.*);
`default_nettype wire

// [verification/sbarb_peer.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Other masters on the shared bus
// ----------------------------------------
module sbarb_peer (
  // Clock
  input wire logic clk,
  // Device drive and bench requests
  input wire logic cbrq_n_oe,
  input wire logic hi_req,
  input wire logic lo_req,
  // Lines toward the device
  output logic bprn_n = 1'b0,
  output logic hi_req_n = 1'b1,
  output logic cbrq_n
);
  // Higher master takes the chain, so priority in goes high
  always @(posedge clk) begin
    bprn_n <= hi_req;
    hi_req_n <= !hi_req;
  end
  // Wired request: low if any party pulls it
  assign cbrq_n = !(cbrq_n_oe || hi_req || lo_req);
endmodule : sbarb_peer
`default_nettype wire

// [verification/tb_system_bus_arbitration_options.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sbarb_regs.svh"
module tb_system_bus_arbitration_options;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, xfer_done = 1'b0;
  logic hi_req = 1'b0, lo_req = 1'b0, module_dma_request_a = 1'b0, module_dma_request_b = 1'b0;
  logic [1:0] ext_term_i = 2'h0;
  logic option0_slot_a_line_i = 1'b0, option0_slot_b_line_i = 1'b0;
  logic option1_slot_a_line_i = 1'b0, option1_slot_b_line_i = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, external_terminate_line;
  logic [31:0] s_axi_rdata, rd;
  logic cbrq_n_o, cbrq_n_oe, breq_n, bpro_n_o, bpro_n_oe, lock_n_o, lock_n_oe, dma_req;
  logic [3:0] option_line_o, option_line_oe;
  logic bprn_n, hi_req_n, cbrq_n_i, seen;
  int error_cnt = 0, checked = 0;
  // Ctrl word per mode, and expected release {higher, lower, done}
  localparam logic [31:0] MODE_CTRL [3] = '{32'h0000_0021, 32'h0000_0023, 32'h0000_0022};
  localparam logic [2:0] MODE_REL [3] = '{3'b100, 3'b110, 3'b111};
  // Clock, 25 ns
  always #12.5 clk = ~clk;
  sbarb_top dut_u (.*);
  sbarb_peer peer_u (.clk, .cbrq_n_oe, .hi_req, .lo_req, .bprn_n, .hi_req_n, .cbrq_n(cbrq_n_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Write; handshakes sampled mid-cycle, released after the edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) if (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) begin
      error_cnt++;
      complete_run();
    end
    chk(32'(r), 32'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) if (!b) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
    end
    if (!b) begin
      error_cnt++;
      complete_run();
    end
    chk(32'(r), 32'(er));
  endtask : axi_rd
  // Has the chosen pin been high within n cycles
  task automatic watch(input int sel, input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(negedge clk);
      s = s | ((sel == 0) ? breq_n : (sel == 1) ? bpro_n_oe : lock_n_oe);
    end
    @(posedge clk);
  endtask : watch
  // Poll status until the owner flag shows
  task automatic wait_own();
    logic [31:0] d;
    d = 32'h0000_0000;
    repeat (30) if (!d[4]) axi_rd(`SBARB_STAT_ADDR, 2'h0, d);
    if (!d[4]) begin
      error_cnt++;
      complete_run();
    end
  endtask : wait_own
  // Other master requests, local transfer ends; did the device let go
  task automatic step(input logic lo, input logic hi, input logic exp);
    logic s1, s2;
    lo_req <= lo;
    hi_req <= hi;
    watch(0, 6, s1);
    xfer_done <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
    watch(0, 30, s2);
    chk(32'(s1 | s2), 32'(exp));
    lo_req <= 1'b0;
    hi_req <= 1'b0;
    wait_own();
  endtask : step
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(`SBARB_CTRL_ADDR, 2'h0, rd);
    chk(rd, `SBARB_CTRL_RESET);
    axi_rd(`SBARB_SLOT_ADDR, 2'h0, rd);
    chk(rd, `SBARB_SLOT_RESET);
    axi_rd(4'hc, 2'h2, rd);
    chk(rd, 32'h0000_0000);
    axi_wr(4'hc, 32'hffff_ffff, 2'h2);
    axi_wr(`SBARB_STAT_ADDR, 32'hffff_ffff, 2'h0);
    // Every mode, parallel then serial scheme
    for (int s = 0; s < 2; s++) for (int m = 0; m < 3; m++) begin
      axi_wr(`SBARB_CTRL_ADDR, MODE_CTRL[m] | (32'(s) << `SBARB_CTRL_SERIAL), 2'h0);
      wait_own();
      step(1'b0, 1'b0, MODE_REL[m][0]);
      step(1'b1, 1'b0, MODE_REL[m][1]);
      step(1'b0, 1'b1, MODE_REL[m][2]);
    end
    // Lock requested, option off, then on
    axi_wr(`SBARB_CTRL_ADDR, 32'h0000_0031, 2'h0);
    wait_own();
    watch(2, 8, seen);
    chk(32'(seen), 32'h0000_0000);
    axi_wr(`SBARB_CTRL_ADDR, 32'h0000_0039, 2'h0);
    wait_own();
    watch(2, 8, seen);
    chk(32'(seen), 32'h0000_0001);
    chk(32'(lock_n_o), 32'h0000_0000);
    axi_wr(`SBARB_CTRL_ADDR, 32'h0000_0019, 2'h0);
    xfer_done <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
    watch(0, 20, seen);
    chk(32'(seen), 32'h0000_0001);
    chk(32'(lock_n_oe), 32'h0000_0000);
    // Parallel scheme, idle, priority held: no priority out
    watch(1, 8, seen);
    chk(32'(seen), 32'h0000_0000);
    // Serial scheme, idle, priority held
    axi_wr(`SBARB_CTRL_ADDR, 32'h0000_0004, 2'h0);
    watch(1, 20, seen);
    chk(32'(seen), 32'h0000_0001);
    // Slot lines
    ext_term_i <= 2'b10;
    option0_slot_a_line_i <= 1'b1;
    option1_slot_b_line_i <= 1'b1;
    axi_wr(`SBARB_SLOT_ADDR, 32'h0000_0a18, 2'h0);
    axi_rd(`SBARB_SLOT_ADDR, 2'h0, rd);
    chk(rd, 32'h0000_0a18);
    chk(32'(option_line_oe), 32'h0000_0006);
    chk(32'(option_line_o & option_line_oe), 32'h0000_0002);
    chk(32'(external_terminate_line), 32'h0000_0002);
    axi_rd(`SBARB_STAT_ADDR, 2'h0, rd);
    chk(32'(rd[14:9]), 32'h0000_0026);
    // Every route code against every request pair
    for (int k = 0; k < 16; k++) begin
      module_dma_request_a <= k[0];
      module_dma_request_b <= k[1];
      axi_wr(`SBARB_SLOT_ADDR, 32'(k[3:2]) << `SBARB_SLOT_DMA_LO, 2'h0);
      axi_rd(`SBARB_SLOT_ADDR, 2'h0, rd);
      chk(32'(dma_req), 32'((k[3:2] == 1) ? k[1] : (k[3:2] == 2) ? k[0] : k[0] | k[1]));
    end
    complete_run();
  end
endmodule : tb_system_bus_arbitration_options
`default_nettype wire
